// *** logic/scb_bus_front.v ***
// serial line front end: synchronises clock and data, finds edges, start and stop
// assumes both pins are asynchronous to mclk and far slower than it
module scb_bus_front (
    input  wire mclk,
    input  wire srst,
    input  wire sclPin,
    input  wire sdaPin,
    output reg  sclRise,
    output reg  sclFall,
    output reg  sdaLevel,
    output reg  startSeen,
    output reg  stopSeen
);
    reg [1:0] sclMeta;
    reg [1:0] sdaMeta;
    reg       sclLevel;

    // ****************************************************************
    // two-stage sync, then a third stage for edge finding
    // ****************************************************************
    always @(posedge mclk) begin
        if (srst) begin
            sclMeta   <= 2'h3;
            sdaMeta   <= 2'h3;
            sclLevel  <= 1'b1;
            sdaLevel  <= 1'b1;
            sclRise   <= 1'b0;
            sclFall   <= 1'b0;
            startSeen <= 1'b0;
            stopSeen  <= 1'b0;
        end else begin
            sclMeta   <= {sclMeta[0], sclPin};
            sdaMeta   <= {sdaMeta[0], sdaPin};
            sclLevel  <= sclMeta[1];
            sdaLevel  <= sdaMeta[1];
            sclRise   <= sclMeta[1] & ~sclLevel;
            sclFall   <= ~sclMeta[1] & sclLevel;
            // data moving while clock stays high marks frame bounds
            startSeen <= sclMeta[1] & sclLevel & sdaLevel & ~sdaMeta[1];
            stopSeen  <= sclMeta[1] & sclLevel & ~sdaLevel & sdaMeta[1];
        end
    end
endmodule

// *** logic/scb_consts.vh ***
// constants for the clock buffer control port: register map, fields, resets
// assumes inclusion by the control port only
`ifndef SCB_CONSTS_VH
`define SCB_CONSTS_VH

// ****************************************************************
// register indices
// ****************************************************************
`define SCB_REG_MODE_FREQ_UPPER 8'h00
`define SCB_REG_ENABLES_LOW     8'h01
`define SCB_REG_ENABLES_MID     8'h02
`define SCB_REG_BYTE_COUNT      8'h07

// ****************************************************************
// fields of the mode, frequency and upper enable register
// ****************************************************************
`define SCB_POS_PLL_MODE_HI     7
`define SCB_POS_PLL_MODE_LO     6
`define SCB_POS_UPPER_EN_HI     5
`define SCB_POS_UPPER_EN_LO     3
`define SCB_POS_FREQ_SEL        0
`define SCB_COUNT_WIDTH         5

// ****************************************************************
// reset values
// ****************************************************************
`define SCB_RST_ENABLES         8'hff
`define SCB_RST_UPPER_EN        3'h7
`define SCB_RST_BYTE_COUNT      5'h08

// ****************************************************************
// three-level strap coding and write addresses
// ****************************************************************
`define SCB_STRAP_LOW           2'h0
`define SCB_STRAP_MID           2'h1
`define SCB_STRAP_HIGH          2'h2
`define SCB_ADDR_00             8'hd8
`define SCB_ADDR_0M             8'hda
`define SCB_ADDR_01             8'hde
`define SCB_ADDR_M0             8'hc2
`define SCB_ADDR_MM             8'hc4
`define SCB_ADDR_M1             8'hc6
`define SCB_ADDR_10             8'hca
`define SCB_ADDR_1M             8'hcc
`define SCB_ADDR_11             8'hce

`endif

// *** logic/scb_ctrl_port.v ***
// serial control port of a 19-pair clock buffer: block transfers, enables, readback
// assumes a system management host on the two-wire link and strap pins steady at reset
`include "scb_consts.vh"

// How it works
// - ack address and index after start
// - ack count and each data byte, store the first count bytes sequentially
// - first returned byte is the count
// - then registers from index onward sequentially
// - write address from two three-level straps
// - byte 0 bits 7:6 show latched pll mode
// - byte 0 bit 0 shows frequency strap
// - per-pair enable, reset one, zero forces low
// - enables map bytes 1, 2, byte 0 bits 5:3
// - writable five-bit readback count, default eight
module scb_ctrl_port (
    input  wire        mclk,
    input  wire        srst,
    input  wire        sclPin,
    input  wire        sdaPin,
    output reg         sdaOut,
    output reg         sdaOe,
    input  wire [1:0]  addrStrap0,
    input  wire [1:0]  addrStrap1,
    input  wire [1:0]  pllModeStrap,
    input  wire        freqSelStrap,
    output reg  [18:0] outputPairEnable,
    output reg         strapsLatched
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_RX    = 3'h1;
    localparam [2:0] ST_ACK   = 3'h2;
    localparam [2:0] ST_TX    = 3'h3;
    localparam [2:0] ST_TXACK = 3'h4;

    localparam [1:0] PH_ADDR  = 2'h0;
    localparam [1:0] PH_INDEX = 2'h1;
    localparam [1:0] PH_COUNT = 2'h2;
    localparam [1:0] PH_DATA  = 2'h3;

    wire sclRise;
    wire sclFall;
    wire sdaLevel;
    wire startSeen;
    wire stopSeen;

    reg  [2:0] state;
    reg  [1:0] phase;
    reg  [3:0] bitCnt;
    reg  [7:0] rxShift;
    reg  [7:0] txShift;
    reg        readMode;
    reg        hostAck;
    reg  [7:0] index;
    reg  [7:0] remain;
    reg  [7:0] devAddr;
    reg  [1:0] pllMode;
    reg        freqSel;
    reg  [`SCB_COUNT_WIDTH-1:0] readCount;
    reg  [7:0] enLow;
    reg  [7:0] enMid;
    reg  [2:0] enUpper;
    reg  [1:0] strapA0Meta;
    reg  [1:0] strapA0;
    reg  [1:0] strapA1Meta;
    reg  [1:0] strapA1;
    reg  [1:0] pllMeta;
    reg  [1:0] pllSync;
    reg        freqMeta;
    reg        freqSync;
    reg  [7:0] readByte;
    reg  [7:0] strapAddr;

    scb_bus_front u_front (
        .mclk      (mclk),
        .srst      (srst),
        .sclPin    (sclPin),
        .sdaPin    (sdaPin),
        .sclRise   (sclRise),
        .sclFall   (sclFall),
        .sdaLevel  (sdaLevel),
        .startSeen (startSeen),
        .stopSeen  (stopSeen)
    );

    // ****************************************************************
    // strap capture, once after reset release
    // ****************************************************************
    always @(posedge mclk) begin
        strapA0Meta <= addrStrap0;
        strapA0     <= strapA0Meta;
        strapA1Meta <= addrStrap1;
        strapA1     <= strapA1Meta;
        pllMeta     <= pllModeStrap;
        pllSync     <= pllMeta;
        freqMeta    <= freqSelStrap;
        freqSync    <= freqMeta;
    end

    always @* begin
        case ({strapA1, strapA0})
            {`SCB_STRAP_LOW,  `SCB_STRAP_LOW }: strapAddr = `SCB_ADDR_00;
            {`SCB_STRAP_LOW,  `SCB_STRAP_MID }: strapAddr = `SCB_ADDR_0M;
            {`SCB_STRAP_LOW,  `SCB_STRAP_HIGH}: strapAddr = `SCB_ADDR_01;
            {`SCB_STRAP_MID,  `SCB_STRAP_LOW }: strapAddr = `SCB_ADDR_M0;
            {`SCB_STRAP_MID,  `SCB_STRAP_MID }: strapAddr = `SCB_ADDR_MM;
            {`SCB_STRAP_MID,  `SCB_STRAP_HIGH}: strapAddr = `SCB_ADDR_M1;
            {`SCB_STRAP_HIGH, `SCB_STRAP_LOW }: strapAddr = `SCB_ADDR_10;
            {`SCB_STRAP_HIGH, `SCB_STRAP_MID }: strapAddr = `SCB_ADDR_1M;
            {`SCB_STRAP_HIGH, `SCB_STRAP_HIGH}: strapAddr = `SCB_ADDR_11;
            default:                            strapAddr = `SCB_ADDR_00;
        endcase
    end

    // ****************************************************************
    // register read mux
    // ****************************************************************
    always @* begin
        case (index)
            `SCB_REG_MODE_FREQ_UPPER: readByte = {pllMode, enUpper, 2'h0, freqSel};
            `SCB_REG_ENABLES_LOW:     readByte = enLow;
            `SCB_REG_ENABLES_MID:     readByte = enMid;
            `SCB_REG_BYTE_COUNT:      readByte = {3'h0, readCount};
            default:                  readByte = 8'h00;
        endcase
    end

    // ****************************************************************
    // link engine and register writes
    // ****************************************************************
    always @(posedge mclk) begin
        if (srst) begin
            state            <= ST_IDLE;
            phase            <= PH_ADDR;
            bitCnt           <= 4'h0;
            rxShift          <= 8'h00;
            txShift          <= 8'h00;
            readMode         <= 1'b0;
            hostAck          <= 1'b0;
            index            <= 8'h00;
            remain           <= 8'h00;
            sdaOut           <= 1'b0;
            sdaOe            <= 1'b0;
            devAddr          <= `SCB_ADDR_00;
            pllMode          <= 2'h0;
            freqSel          <= 1'b0;
            strapsLatched    <= 1'b0;
            readCount        <= `SCB_RST_BYTE_COUNT;
            enLow            <= `SCB_RST_ENABLES;
            enMid            <= `SCB_RST_ENABLES;
            enUpper          <= `SCB_RST_UPPER_EN;
            outputPairEnable <= {19{1'b1}};
        end else begin
            sdaOut           <= 1'b0;
            outputPairEnable <= {enUpper, enMid, enLow};
            // straps are read after the sync chain has settled post reset
            if (!strapsLatched) begin
                strapsLatched <= 1'b1;
                devAddr       <= strapAddr;
                pllMode       <= pllSync;
                freqSel       <= freqSync;
            end
            if (stopSeen) begin
                state <= ST_IDLE;
                phase <= PH_ADDR;
                sdaOe <= 1'b0;
            end else if (startSeen) begin
                // repeated start keeps the index pointer
                state  <= ST_RX;
                phase  <= PH_ADDR;
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (sclRise) begin
                            rxShift <= {rxShift[6:0], sdaLevel};
                            bitCnt  <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == 4'h8) begin
                            bitCnt <= 4'h0;
                            state  <= ST_ACK;
                            sdaOe  <= 1'b1;
                            case (phase)
                                PH_ADDR: begin
                                    // other addresses leave the line alone
                                    if (rxShift[7:1] != devAddr[7:1]) begin
                                        state <= ST_IDLE;
                                        sdaOe <= 1'b0;
                                    end else begin
                                        readMode <= rxShift[0];
                                        phase    <= PH_INDEX;
                                    end
                                end
                                PH_INDEX: begin
                                    index <= rxShift;
                                    phase <= PH_COUNT;
                                end
                                PH_COUNT: begin
                                    remain <= rxShift;
                                    phase  <= PH_DATA;
                                end
                                PH_DATA: begin
                                    if (remain != 8'h00) begin
                                        remain <= remain - 8'h01;
                                        index  <= index + 8'h01;
                                        case (index)
                                            `SCB_REG_MODE_FREQ_UPPER:
                                                enUpper <= rxShift[`SCB_POS_UPPER_EN_HI:`SCB_POS_UPPER_EN_LO];
                                            `SCB_REG_ENABLES_LOW:  enLow     <= rxShift;
                                            `SCB_REG_ENABLES_MID:  enMid     <= rxShift;
                                            `SCB_REG_BYTE_COUNT:   readCount <= rxShift[`SCB_COUNT_WIDTH-1:0];
                                            default:               readCount <= readCount;
                                        endcase
                                    end
                                end
                                default: phase <= PH_ADDR;
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            if (readMode && phase == PH_INDEX) begin
                                // first byte out is the count
                                txShift <= {3'h0, readCount};
                                // bit 7 of the count byte is always zero, so the line is pulled low
                                sdaOe   <= 1'b1;
                                phase   <= PH_DATA;
                                state   <= ST_TX;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (sclFall) begin
                            if (bitCnt == 4'h7) begin
                                bitCnt <= 4'h0;
                                sdaOe  <= 1'b0;
                                state  <= ST_TXACK;
                            end else begin
                                bitCnt  <= bitCnt + 4'h1;
                                txShift <= {txShift[6:0], 1'b0};
                                sdaOe   <= ~txShift[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (sclRise) begin
                            hostAck <= ~sdaLevel;
                        end else if (sclFall) begin
                            if (hostAck) begin
                                txShift <= readByte;
                                sdaOe   <= ~readByte[7];
                                index   <= index + 8'h01;
                                state   <= ST_TX;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// *** verif/scb_ctrl_port_sva.sv ***
// checker for the clock buffer control port: straps, data enable timing, enables
// assumes a link clock far slower than mclk, as the bench makes it
module scb_ctrl_port_sva (
    input wire        mclk,
    input wire        srst,
    input wire        sclPin,
    input wire        sdaOut,
    input wire        sdaOe,
    input wire [18:0] outputPairEnable,
    input wire        strapsLatched
);
    // ****************************************
    // link and register properties
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_reset_state: assert property ($fell(srst) |-> outputPairEnable == 19'h7ffff && !sdaOe)
        else $error("enables or data enable off their reset value");
    a_straps_latch: assert property ($fell(srst) |-> ##[1:2] strapsLatched)
        else $error("straps not latched after reset");
    a_latch_kept: assert property (strapsLatched |=> strapsLatched)
        else $error("strap latch dropped");
    a_open_drain: assert property (sdaOut == 1'b0)
        else $error("data output drives high");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclPin)
        else $error("data enable moved while clock high");
    a_oe_held_high: assert property ($rose(sclPin) |=> $stable(sdaOe)[*3])
        else $error("data enable unstable in clock high phase");
    a_store_acked: assert property ($changed(outputPairEnable) |-> ##[0:12] sdaOe)
        else $error("enable store without acknowledge");
    // longest low run: ack then eight zero bits
    a_oe_released: assert property ($rose(sdaOe) |-> ##[1:80] !sdaOe)
        else $error("data line held low too long");
endmodule

bind scb_ctrl_port scb_ctrl_port_sva chk (
    .mclk(mclk), .srst(srst), .sclPin(sclPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .outputPairEnable(outputPairEnable), .strapsLatched(strapsLatched)
);

// *** verif/scb_host_model.sv ***
// host model of the management link: makes the link clock, moves data mid-low
// assumes the bench resolves the data wire from this model and the device enable
module scb_host_model (
    output logic sclPin,
    output logic sdaRel,
    input  wire  sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // bit and frame tasks
    // ****************************************
    initial begin
        sclPin = 1'b1;
        sdaRel = 1'b1;
    end
    // 200 ns bit: 125 low, 75 high; clock stands high between frames
    task automatic bitXfer(input logic tx, output logic rx);
        #50 sdaRel = tx;
        #75 sclPin = 1'b1;
        #50 rx = sdaLine;
        #25 sclPin = 1'b0;
    endtask
    task automatic startBit();
        if (!sclPin) begin
            #50 sdaRel = 1'b1;
            #75 sclPin = 1'b1;
        end
        #50 sdaRel = 1'b0;
        #75 sclPin = 1'b0;
    endtask
    task automatic stopBit();
        #50 sdaRel = 1'b0;
        #75 sclPin = 1'b1;
        #50 sdaRel = 1'b1;
        #25;
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(b[i], r);
        end
        bitXfer(1'b1, r);
        ack = !r;
    endtask
    task automatic recvByte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(1'b1, b[i]);
        end
        bitXfer(last, r);
    endtask
endmodule

// *** verif/tb_top.sv ***
// bench for the clock buffer control port: strap addresses, block writes and reads
// assumes the host model on the link and a pull-up on the data wire
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, srst, sclPin, sdaRel, sdaOut, sdaOe, freqSelStrap, strapsLatched, ack;
    logic [1:0]  addrStrap0, addrStrap1, pllModeStrap;
    logic [18:0] outputPairEnable;
    logic [7:0]  devAddr;
    int          failCount = 0, nCompared = 0, cycles = 0;
    logic [7:0]  addrTable [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
    // pull-up: a released line reads high, an enabled device shows its output value
    wire         sdaPin = sdaRel & (sdaOe ? sdaOut : 1'b1);

    scb_ctrl_port uut (.mclk(mclk), .srst(srst), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrStrap0(addrStrap0), .addrStrap1(addrStrap1), .pllModeStrap(pllModeStrap),
        .freqSelStrap(freqSelStrap), .outputPairEnable(outputPairEnable), .strapsLatched(strapsLatched));
    scb_host_model host (.sclPin(sclPin), .sdaRel(sdaRel), .sdaLine(sdaPin));

    // ****************************************
    // tasks
    // ****************************************
    task automatic chkVal(input string name, input logic [18:0] exp, input logic [18:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finalReport();
        $display("compared %0d mismatched %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic doReset();
        @(negedge mclk);
        srst = 1'b1;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        repeat (6) @(negedge mclk);
    endtask
    task automatic blockWrite(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] d[$]);
        host.startBit();
        host.sendByte(devAddr, ack);
        chkVal("write address ack", 1, ack);
        host.sendByte(idx, ack);
        chkVal("index ack", 1, ack);
        host.sendByte(cnt, ack);
        chkVal("count ack", 1, ack);
        foreach (d[i]) begin
            host.sendByte(d[i], ack);
            chkVal("data ack", 1, ack);
        end
        host.stopBit();
    endtask
    task automatic blockRead(input logic [7:0] idx, input logic [7:0] exp[$]);
        logic [7:0] b;
        host.startBit();
        host.sendByte(devAddr, ack);
        host.sendByte(idx, ack);
        chkVal("read index ack", 1, ack);
        host.startBit();
        host.sendByte(devAddr | 8'h01, ack);
        chkVal("read address ack", 1, ack);
        foreach (exp[i]) begin
            host.recvByte(i == exp.size() - 1, b);
            chkVal("read byte", exp[i], b);
        end
        host.stopBit();
    endtask

    // ****************************************
    // clock, timeout and test sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // run needs about 5000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            finalReport();
        end
    end
    initial begin
        srst = 1'b1;
        pllModeStrap = 2'h2;
        freqSelStrap = 1'b1;
        for (int k = 0; k < 9; k++) begin
            addrStrap1 = 2'(k / 3);
            addrStrap0 = 2'(k % 3);
            devAddr = addrTable[k];
            doReset();
            chkVal("reset enables", 19'h7ffff, outputPairEnable);
            chkVal("straps latched", 1, strapsLatched);
            // 0x90 matches none of the nine strap addresses
            host.startBit();
            host.sendByte(8'h90, ack);
            chkVal("foreign address ack", 0, ack);
            host.stopBit();
            host.startBit();
            host.sendByte(devAddr, ack);
            chkVal("own address ack", 1, ack);
            host.stopBit();
        end
        $display("test strap addresses done");
        blockWrite(8'h01, 8'h02, {8'h5a, 8'ha5});
        chkVal("enables after write", 19'h7a55a, outputPairEnable);
        blockWrite(8'h00, 8'h01, {8'h46});
        chkVal("upper enables cleared", 19'h0a55a, outputPairEnable);
        blockWrite(8'h01, 8'h01, {8'h0f, 8'h33});
        chkVal("byte past count", 19'h0a50f, outputPairEnable);
        blockWrite(8'h07, 8'h01, {8'hf3});
        blockRead(8'h00, {8'h13, 8'h81, 8'h0f, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00});
        $display("test block transfers done");
        // other strap levels so both readback fields take their second value
        pllModeStrap = 2'h1;
        freqSelStrap = 1'b0;
        doReset();
        blockRead(8'h07, {8'h08, 8'h08, 8'h00});
        blockRead(8'h00, {8'h08, 8'h78, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00});
        $display("test count default done");
        finalReport();
    end
endmodule
